// *** hdl/amprc_axil.sv ***
// AXI4-Lite slave holding the control and status registers
`timescale 1ns/1ps
module amprc_axil (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // write channels
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // read channels
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // block side
  output logic disp_busy,
  output logic [7:0] module_num,
  input wire logic [31:0] stat_word
);
  // all slave state
  typedef struct packed {
    logic awrdy;
    logic wrdy;
    logic arrdy;
    logic aw_ok;
    logic [7:0] awaddr;
    logic w_ok;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [31:0] ctrl;
  } amprc_axil_t;
  amprc_axil_t q, d;

  // next state: address and data taken in either order
  always_comb begin
    d = q;
    if (s_axi_awvalid && q.awrdy) begin
      d.aw_ok = 1'b1;
      d.awaddr = {s_axi_awaddr[7:2], 2'h0};
    end
    if (s_axi_wvalid && q.wrdy) begin
      d.w_ok = 1'b1;
      d.wdata = s_axi_wdata;
      d.wstrb = s_axi_wstrb;
    end
    if (q.bvalid && s_axi_bready) begin
      d.bvalid = 1'b0;
    end
    // both halves held: commit and answer
    if (q.aw_ok && q.w_ok && !q.bvalid) begin
      d.aw_ok = 1'b0;
      d.w_ok = 1'b0;
      d.bvalid = 1'b1;
      d.bresp = amprc_pkg::RESP_OKAY;
      if (q.awaddr == amprc_pkg::REG_CTRL) begin
        for (int i = 0; i < 4; i++) begin
          if (q.wstrb[i]) begin
            d.ctrl[8*i +: 8] = q.wdata[8*i +: 8];
          end
        end
        d.ctrl = d.ctrl & amprc_pkg::CTRL_MASK;
      end else if (q.awaddr != amprc_pkg::REG_STAT) begin
        d.bresp = amprc_pkg::RESP_SLVERR;
      end
    end
    if (q.rvalid && s_axi_rready) begin
      d.rvalid = 1'b0;
    end
    // reads answer one cycle after the address is taken
    if (s_axi_arvalid && q.arrdy) begin
      d.rvalid = 1'b1;
      d.rresp = amprc_pkg::RESP_OKAY;
      case ({s_axi_araddr[7:2], 2'h0})
        amprc_pkg::REG_CTRL: d.rdata = q.ctrl;
        amprc_pkg::REG_STAT: d.rdata = stat_word;
        default: begin
          d.rdata = 32'h00000000;
          d.rresp = amprc_pkg::RESP_SLVERR;
        end
      endcase
    end
    // one write and one read in flight at most
    d.awrdy = !d.aw_ok && !d.bvalid;
    d.wrdy = !d.w_ok && !d.bvalid;
    d.arrdy = !d.rvalid;
  end

  // registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= '0;
      q.ctrl <= amprc_pkg::CTRL_RST;
    end else begin
      q <= d;
    end
  end

  assign s_axi_awready = q.awrdy;
  assign s_axi_wready = q.wrdy;
  assign s_axi_arready = q.arrdy;
  assign s_axi_bvalid = q.bvalid;
  assign s_axi_bresp = q.bresp;
  assign s_axi_rvalid = q.rvalid;
  assign s_axi_rdata = q.rdata;
  assign s_axi_rresp = q.rresp;
  assign disp_busy = q.ctrl[amprc_pkg::CTRL_BUSY];
  assign module_num = q.ctrl[amprc_pkg::CTRL_MOD +: 8];
endmodule

// *** hdl/amprc_pkg.sv ***
// shared constants and types of the amplifier command responder
package amprc_pkg;
  // operating codes
  localparam logic [7:0] OP_IDENT = 8'h00;
  localparam logic [7:0] OP_CFG = 8'h01;
  localparam logic [7:0] OP_RDOFF = 8'h02;
  localparam logic [7:0] OP_RDCH = 8'h03;
  localparam logic [7:0] OP_RDMUX = 8'h04;
  localparam logic [7:0] OP_FINE = 8'h10;
  localparam logic [7:0] OP_COARSE = 8'h11;
  localparam logic [7:0] OP_PZ = 8'h12;
  localparam logic [7:0] OP_SHAPE = 8'h13;
  localparam logic [7:0] OP_POL = 8'h14;
  localparam logic [7:0] OP_CONF = 8'h15;
  localparam logic [7:0] OP_OFFSET = 8'h16;
  localparam logic [7:0] OP_MUXOFF = 8'h20;
  localparam logic [7:0] OP_MUXON = 8'h21;
  // master identifier bytes and the all-channel selector
  localparam logic [7:0] MID_LO = 8'h01;
  localparam logic [7:0] MID_HI = 8'h00;
  localparam logic [7:0] CH_ALL = 8'h10;
  // error codes
  localparam logic [15:0] ERR_OK = 16'h0000;
  localparam logic [15:0] ERR_BUSY = 16'hFF00;
  localparam logic [15:0] ERR_MSG = 16'hFF01;
  localparam logic [15:0] ERR_RANGE = 16'hFF02;
  // upper limits of set values
  localparam logic [7:0] MAX_BYTE = 8'hFF;
  localparam logic [7:0] MAX_COARSE = 8'h07;
  localparam logic [7:0] MAX_SHAPE = 8'h03;
  localparam logic [7:0] MAX_BIT = 8'h01;
  // received message lengths
  localparam logic [3:0] RX_READ = 4'h6;
  localparam logic [3:0] RX_SET = 4'h8;
  localparam logic [3:0] RX_OVER = 4'h9;
  // response lengths and layout, in bytes
  localparam logic [6:0] LEN_ID = 7'h24;
  localparam logic [6:0] LEN_CFG = 7'h66;
  localparam logic [6:0] LEN_OFF = 7'h04;
  localparam logic [6:0] LEN_CH = 7'h08;
  localparam logic [6:0] LEN_CHALL = 7'h62;
  localparam logic [6:0] LEN_ERR = 7'h02;
  localparam logic [6:0] LEN_MUX = 7'h02;
  localparam logic [6:0] HDR_MID = 7'h04;
  localparam logic [6:0] HDR_ERR = 7'h02;
  localparam logic [6:0] GRP = 7'h06;
  localparam logic [6:0] BODY = 7'h60;
  // register map, byte addresses
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STAT = 8'h04;
  localparam logic [31:0] CTRL_RST = 32'h00000000;
  localparam logic [31:0] CTRL_MASK = 32'h0000FF01;
  localparam int CTRL_BUSY = 0;
  localparam int CTRL_MOD = 8;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // sequencer states, one-hot
  typedef enum logic [2:0] {
    ST_RX = 3'h1,
    ST_EXEC = 3'h2,
    ST_TX = 3'h4
  } amprc_state_t;
  // response formats
  typedef enum logic [2:0] {
    K_ERR, K_ID, K_CFG, K_OFF, K_CH, K_MUX
  } amprc_kind_t;
endpackage

// *** hdl/amprc_top.sv ***
// command interpreter and response builder of the amplifier module
//
// Decided for this implementation: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
module amprc_top #(
  parameter int NCH = 16,
  // identifier text, value is arbitrary
  parameter logic [127:0] ID_TEXT = "AMP16 Version 10"
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // command bytes from the network master
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_data,
  input wire logic cmd_last,
  output logic cmd_ready,
  // response bytes towards the master
  output logic resp_valid,
  output logic [7:0] resp_data,
  output logic resp_last,
  input wire logic resp_ready,
  // register bus
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  // all sequencer state and stored settings
  typedef struct packed {
    amprc_pkg::amprc_state_t st;
    logic [7:0][7:0] rx;        // received bytes
    logic [3:0] cnt;            // bytes received, saturating
    logic [NCH-1:0][7:0] fine;
    logic [NCH-1:0][7:0] pz;
    logic [NCH-1:0][2:0] coarse;
    logic [NCH-1:0][1:0] shape;
    logic [NCH-1:0] pol;
    logic [NCH-1:0] conf;
    logic [7:0] offset;
    logic mux_en;
    logic [3:0] last_ch;
    logic [15:0] err;
    amprc_pkg::amprc_kind_t kind;
    logic [7:0] rch;            // channel of a channel read
    logic [6:0] idx;            // next response byte
    logic [6:0] len;            // response length
    logic cmd_rdy;
    logic rvld;
    logic [7:0] rdat;
    logic rlst;
  } amprc_core_t;
  amprc_core_t q, d;

  logic disp_busy;         // display brightness being set
  logic [7:0] module_num;  // own address on the network
  logic [31:0] stat_word;

  // decoded fields of the held message
  logic [7:0] op;
  logic [7:0] chn;
  logic [7:0] val;
  logic hdr_ok;
  logic mod_hit;
  logic chn_ok;
  logic rd_ok;
  logic set_ok;
  logic exec;

  assign op = q.rx[4];
  assign chn = q.rx[5];
  assign val = q.rx[6];
  assign exec = (q.st == amprc_pkg::ST_EXEC);
  // header as the master must send it
  assign hdr_ok = (q.cnt >= amprc_pkg::RX_READ)
    && (q.rx[0] == amprc_pkg::MID_LO)
    && (q.rx[1] == amprc_pkg::MID_HI)
    && (q.rx[3] == 8'h00);
  assign mod_hit = (q.rx[2] == module_num);
  assign chn_ok = (chn < 8'(NCH)) || (chn == amprc_pkg::CH_ALL);
  assign rd_ok = (q.cnt == amprc_pkg::RX_READ);
  assign set_ok = (q.cnt == amprc_pkg::RX_SET) && (q.rx[7] == 8'h00);
  assign stat_word = {7'h00, q.st == amprc_pkg::ST_TX, q.last_ch,
    3'h0, q.mux_en, q.err};

  // upper limit of each set value
  function automatic logic [7:0] set_max(input logic [7:0] o);
    case (o)
      amprc_pkg::OP_COARSE: set_max = amprc_pkg::MAX_COARSE;
      amprc_pkg::OP_SHAPE: set_max = amprc_pkg::MAX_SHAPE;
      amprc_pkg::OP_POL: set_max = amprc_pkg::MAX_BIT;
      amprc_pkg::OP_CONF: set_max = amprc_pkg::MAX_BIT;
      default: set_max = amprc_pkg::MAX_BYTE;
    endcase
  endfunction

  // one byte of a channel triple: fine, pole-zero, status
  function automatic logic [7:0] ch_byte(input amprc_core_t s,
      input logic [3:0] c, input logic [6:0] w);
    case (w)
      7'h00: ch_byte = s.fine[c];
      7'h02: ch_byte = s.pz[c];
      // seven-bit status word, high bits zero
      7'h04: ch_byte = {1'b0, s.conf[c], s.pol[c], s.shape[c],
        s.coarse[c]};
      default: ch_byte = 8'h00; // high bytes are blank
    endcase
  endfunction

  // response byte i of the current answer
  function automatic logic [7:0] tx_byte(input amprc_core_t s,
      input logic [6:0] i);
    logic [6:0] b;
    logic [6:0] e;
    logic [127:0] t;
    b = 7'h00;
    t = ID_TEXT;
    // the identify and configuration answers start with the master id
    e = (s.kind == amprc_pkg::K_ID || s.kind == amprc_pkg::K_CFG)
      ? amprc_pkg::HDR_ERR : 7'h00;
    if (s.kind == amprc_pkg::K_MUX) begin
      // status byte then a blank byte
      tx_byte = (i == 7'h00) ? {s.mux_en, 3'h0, s.last_ch}
        : 8'h00;
    end else if (e != 7'h00 && i == 7'h00) begin
      tx_byte = amprc_pkg::MID_LO;
    end else if (e != 7'h00 && i == 7'h01) begin
      tx_byte = amprc_pkg::MID_HI;
    end else if (i == e) begin
      tx_byte = s.err[7:0];
    end else if (i == e + 7'h01) begin
      tx_byte = s.err[15:8];
    end else begin
      case (s.kind)
        amprc_pkg::K_ID: begin
          b = i - amprc_pkg::HDR_MID;
          t = ID_TEXT << {b[4:1], 3'h0};
          tx_byte = b[0] ? 8'h00 : t[127:120];
        end
        amprc_pkg::K_CFG: begin
          b = i - amprc_pkg::HDR_MID;
          if (b == amprc_pkg::BODY) begin
            tx_byte = s.offset;
          end else if (b > amprc_pkg::BODY) begin
            tx_byte = 8'h00;
          end else begin
            tx_byte = ch_byte(s, 4'(b / amprc_pkg::GRP),
              b % amprc_pkg::GRP);
          end
        end
        amprc_pkg::K_OFF: begin
          tx_byte = (i == amprc_pkg::HDR_ERR) ? s.offset
            : 8'h00;
        end
        amprc_pkg::K_CH: begin
          b = i - amprc_pkg::HDR_ERR;
          // all-channel read walks every channel in order
          if (s.rch == amprc_pkg::CH_ALL) begin
            tx_byte = ch_byte(s, 4'(b / amprc_pkg::GRP),
              b % amprc_pkg::GRP);
          end else begin
            tx_byte = ch_byte(s, s.rch[3:0], b);
          end
        end
        default: tx_byte = 8'h00;
      endcase
    end
  endfunction

  // register bus slave
  amprc_axil u_regs (
    .aclk(aclk),
    .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .disp_busy(disp_busy),
    .module_num(module_num),
    .stat_word(stat_word)
  );

  // sequencer: collect, execute, answer
  always_comb begin
    d = q;
    case (q.st)
      amprc_pkg::ST_RX: begin
        if (cmd_valid && q.cmd_rdy) begin
          // bytes past the eighth only mark the message as too long
          if (q.cnt < amprc_pkg::RX_SET) begin
            d.rx[q.cnt[2:0]] = cmd_data;
          end
          if (q.cnt != amprc_pkg::RX_OVER) begin
            d.cnt = q.cnt + 4'h1;
          end
          if (cmd_last) begin
            d.st = amprc_pkg::ST_EXEC;
            d.cmd_rdy = 1'b0;
          end
        end
      end
      amprc_pkg::ST_EXEC: begin
        d.st = amprc_pkg::ST_TX;
        d.cnt = 4'h0;
        d.idx = 7'h00;
        d.kind = amprc_pkg::K_ERR;
        d.len = amprc_pkg::LEN_ERR;
        d.err = amprc_pkg::ERR_OK;
        d.rch = chn;
        if (!hdr_ok) begin
          d.err = amprc_pkg::ERR_MSG;
        end else if (!mod_hit) begin
          // addressed to another module: stay silent
          d.st = amprc_pkg::ST_RX;
          d.cmd_rdy = 1'b1;
        end else if (disp_busy) begin
          d.err = amprc_pkg::ERR_BUSY;
        end else begin
          case (op)
            amprc_pkg::OP_IDENT,
            amprc_pkg::OP_CFG,
            amprc_pkg::OP_RDOFF,
            amprc_pkg::OP_RDMUX,
            amprc_pkg::OP_MUXOFF,
            amprc_pkg::OP_MUXON: begin
              if (!rd_ok || chn != 8'h00) begin
                d.err = amprc_pkg::ERR_MSG;
              end else begin
                case (op)
                  amprc_pkg::OP_IDENT: begin
                    d.kind = amprc_pkg::K_ID;
                    d.len = amprc_pkg::LEN_ID;
                  end
                  amprc_pkg::OP_CFG: begin
                    d.kind = amprc_pkg::K_CFG;
                    d.len = amprc_pkg::LEN_CFG;
                  end
                  amprc_pkg::OP_RDOFF: begin
                    d.kind = amprc_pkg::K_OFF;
                    d.len = amprc_pkg::LEN_OFF;
                  end
                  amprc_pkg::OP_RDMUX: begin
                    d.kind = amprc_pkg::K_MUX;
                    d.len = amprc_pkg::LEN_MUX;
                  end
                  amprc_pkg::OP_MUXON: d.mux_en = 1'b1;
                  default: d.mux_en = 1'b0;
                endcase
              end
            end
            amprc_pkg::OP_RDCH: begin
              if (!rd_ok || !chn_ok) begin
                d.err = amprc_pkg::ERR_MSG;
              end else begin
                d.kind = amprc_pkg::K_CH;
                d.len = (chn == amprc_pkg::CH_ALL)
                  ? amprc_pkg::LEN_CHALL : amprc_pkg::LEN_CH;
                if (chn != amprc_pkg::CH_ALL) begin
                  d.last_ch = chn[3:0];
                end
              end
            end
            amprc_pkg::OP_OFFSET: begin
              if (!set_ok || chn != 8'h00) begin
                d.err = amprc_pkg::ERR_MSG;
              end else begin
                d.offset = val;
              end
            end
            amprc_pkg::OP_FINE,
            amprc_pkg::OP_COARSE,
            amprc_pkg::OP_PZ,
            amprc_pkg::OP_SHAPE,
            amprc_pkg::OP_POL,
            amprc_pkg::OP_CONF: begin
              if (!set_ok || !chn_ok) begin
                d.err = amprc_pkg::ERR_MSG;
              end else if (val > set_max(op)) begin
                // nothing is stored when the value is refused
                d.err = amprc_pkg::ERR_RANGE;
              end else begin
                if (chn != amprc_pkg::CH_ALL) begin
                  d.last_ch = chn[3:0];
                end
                for (int c = 0; c < NCH; c++) begin
                  if (chn == amprc_pkg::CH_ALL || chn == 8'(c)) begin
                    case (op)
                      amprc_pkg::OP_FINE: d.fine[c] = val;
                      amprc_pkg::OP_COARSE: d.coarse[c] = val[2:0];
                      amprc_pkg::OP_PZ: d.pz[c] = val;
                      amprc_pkg::OP_SHAPE: d.shape[c] = val[1:0];
                      amprc_pkg::OP_POL: d.pol[c] = val[0];
                      default: d.conf[c] = val[0];
                    endcase
                  end
                end
              end
            end
            default: d.err = amprc_pkg::ERR_MSG;
          endcase
        end
      end
      amprc_pkg::ST_TX: begin
        // load the next byte when the output slot is free
        if (!q.rvld || resp_ready) begin
          if (q.idx == q.len) begin
            d.rvld = 1'b0;
            d.rlst = 1'b0;
            d.st = amprc_pkg::ST_RX;
            d.cmd_rdy = 1'b1;
          end else begin
            d.rvld = 1'b1;
            d.rdat = tx_byte(q, q.idx);
            d.rlst = (q.idx + 7'h01 == q.len);
            d.idx = q.idx + 7'h01;
          end
        end
      end
      default: d.st = amprc_pkg::ST_RX;
    endcase
  end

  // state register; reset clears every setting
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= '0;
      q.st <= amprc_pkg::ST_RX;
      q.kind <= amprc_pkg::K_ERR;
      q.cmd_rdy <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign cmd_ready = q.cmd_rdy;
  assign resp_valid = q.rvld;
  assign resp_data = q.rdat;
  assign resp_last = q.rlst;

  // checks on the sequencer
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  logic run_ok;
  assign run_ok = exec && hdr_ok && mod_hit && !disp_busy;

  a_pz_store: assert property (run_ok && op == amprc_pkg::OP_PZ
    && set_ok && chn < 8'(NCH) |=> q.pz[$past(chn[3:0])] == $past(val))
    else $error("pole-zero value not stored");
  a_shape_range: assert property (run_ok
    && op == amprc_pkg::OP_SHAPE && set_ok && chn_ok && val > 8'h03
    |=> q.err == amprc_pkg::ERR_RANGE && q.shape == $past(q.shape))
    else $error("shape out of range not refused");
  a_pol_store: assert property (run_ok && op == amprc_pkg::OP_POL
    && set_ok && chn == amprc_pkg::CH_ALL && val == 8'h01
    |=> &q.pol) else $error("polarity not applied to all");
  a_conf_range: assert property (run_ok
    && op == amprc_pkg::OP_CONF && set_ok && chn_ok && val > 8'h01
    |=> $stable(q.conf)) else $error("bad configuration stored");
  a_off_store: assert property (run_ok
    && op == amprc_pkg::OP_OFFSET && set_ok && chn == 8'h00
    |=> q.offset == $past(val)) else $error("offset not stored");
  a_id_head: assert property (q.rvld && q.kind == amprc_pkg::K_ID
    && q.idx <= 7'h02 |-> q.rdat == ((q.idx == 7'h01)
    ? amprc_pkg::MID_LO : amprc_pkg::MID_HI))
    else $error("identify header wrong");
  a_set_reply: assert property (run_ok
    && op == amprc_pkg::OP_FINE |=> q.len == amprc_pkg::LEN_ERR
    && q.kind == amprc_pkg::K_ERR) else $error("set reply length");
  a_mux_len: assert property (run_ok && rd_ok
    && op == amprc_pkg::OP_RDMUX && chn == 8'h00
    |=> q.len == amprc_pkg::LEN_MUX) else $error("mux reply length");
  a_busy_reply: assert property (exec && hdr_ok && mod_hit
    && disp_busy |=> q.err == amprc_pkg::ERR_BUSY
    && $stable(q.offset) && $stable(q.mux_en))
    else $error("busy module executed command");
  a_reset_clear: assert property ($rose(aresetn)
    |-> q.offset == 8'h00 && !q.mux_en && q.fine == '0)
    else $error("settings not cleared by reset");
endmodule

// *** tb/amprc_net_master.sv ***
// network master model: sends command bytes, gathers response bytes
`timescale 1ns/1ps
module amprc_net_master (
  // clock
  input wire logic aclk,
  // command stream
  output logic cmd_valid,
  output logic [7:0] cmd_data,
  output logic cmd_last,
  input wire logic cmd_ready,
  // response stream
  input wire logic resp_valid,
  input wire logic [7:0] resp_data,
  input wire logic resp_last,
  output logic resp_ready
);
  logic [7:0] rx[$]; // bytes of the last response
  initial begin
    cmd_valid = 1'b0;
    cmd_data = 8'h00;
    cmd_last = 1'b0;
    resp_ready = 1'b0;
  end
  // one message, then its whole response; slow stalls every other cycle
  task automatic xfer(input logic [7:0] op, ch, val, input bit set, slow,
    output bit tmo);
    logic [7:0] m[$];
    int n;
    m = '{8'h01, 8'h00, 8'h00, 8'h00, op, ch};
    if (set) m = {m, val, 8'h00};
    rx = {};
    tmo = 0;
    @(posedge aclk);
    foreach (m[i]) begin
      cmd_valid <= 1'b1;
      cmd_data <= m[i];
      cmd_last <= (i == m.size() - 1);
      n = 0;
      do begin
        @(posedge aclk);
        n++;
      end while (cmd_ready !== 1'b1 && n < 50);
      if (n >= 50) tmo = 1;
    end
    cmd_valid <= 1'b0;
    cmd_last <= 1'b0;
    // a released line must not keep showing the last byte
    cmd_data <= ~m[m.size() - 1];
    n = 0;
    do begin
      resp_ready <= !(slow && n[0]);
      @(posedge aclk);
      n++;
      if (resp_valid === 1'b1 && resp_ready) rx.push_back(resp_data);
    end while (!(resp_valid === 1'b1 && resp_ready && resp_last) && n < 400);
    if (n >= 400) tmo = 1;
    resp_ready <= 1'b0;
  endtask
endmodule

// *** tb/tb.sv ***
// self-checking bench of the amplifier command responder
`timescale 1ns/1ps
module tb;
  logic aclk, aresetn, cv, cl, cr, rv, rl, rr;
  logic [7:0] cd, rd, awa, ara;
  logic awv, awr, wv, wr, bv, bq, arv, arr, rvl, rq;
  logic [31:0] wd, rdat;
  logic [1:0] bresp, rresp;
  int mismatches, checks;
  amprc_top dut (.aclk(aclk), .aresetn(aresetn), .cmd_valid(cv),
    .cmd_data(cd), .cmd_last(cl), .cmd_ready(cr), .resp_valid(rv),
    .resp_data(rd), .resp_last(rl), .resp_ready(rr), .s_axi_awaddr(awa),
    .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wr),
    .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(bq),
    .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_rdata(rdat), .s_axi_rresp(rresp), .s_axi_rvalid(rvl),
    .s_axi_rready(rq));
  amprc_net_master m (.aclk(aclk), .cmd_valid(cv), .cmd_data(cd),
    .cmd_last(cl), .cmd_ready(cr), .resp_valid(rv), .resp_data(rd),
    .resp_last(rl), .resp_ready(rr));
  // 10 MHz clock
  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end
  task automatic report_and_stop();
    if (mismatches == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic cmp(input string nm, input logic [31:0] e, s);
    checks++;
    if (s !== e) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask
  // a bounded wait ran out: count it and stop
  task automatic hang();
    cmp("wait done", 1, 0);
    report_and_stop();
  endtask
  // one message and a byte-by-byte look at its response
  task automatic run(input logic [7:0] op, ch, val, input bit set, slow,
    input logic [7:0] e[$]);
    bit t;
    m.xfer(op, ch, val, set, slow, t);
    if (t) hang();
    cmp("resp length", e.size(), m.rx.size());
    foreach (e[i]) cmp("resp byte", e[i], m.rx[i]);
  endtask
  // register write: address and data offered together
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge aclk);
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    bq <= 1'b1;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
      if (awr) awv <= 1'b0;
      if (wr) wv <= 1'b0;
    end while (bv !== 1'b1 && n < 50);
    if (n >= 50) hang();
    bq <= 1'b0;
    cmp("bresp", 2'h0, bresp);
  endtask
  task automatic axr(input logic [7:0] a, input logic [31:0] e,
    input logic [1:0] r);
    int n;
    @(posedge aclk);
    ara <= a;
    arv <= 1'b1;
    rq <= 1'b1;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
      if (arr) arv <= 1'b0;
    end while (rvl !== 1'b1 && n < 50);
    if (n >= 50) hang();
    rq <= 1'b0;
    cmp("rdata", e, rdat);
    cmp("rresp", r, rresp);
  endtask
  task automatic sc_sets();
    run(8'h12, 8'h03, 8'hFF, 1, 0, '{8'h00, 8'h00});
    run(8'h13, 8'h03, 8'h04, 1, 0, '{8'h02, 8'hFF});
    run(8'h13, 8'h03, 8'h03, 1, 0, '{8'h00, 8'h00});
    run(8'h14, 8'h03, 8'h01, 1, 0, '{8'h00, 8'h00});
    run(8'h14, 8'h10, 8'h01, 1, 0, '{8'h00, 8'h00});
    run(8'h15, 8'h03, 8'h01, 1, 0, '{8'h00, 8'h00});
    run(8'h15, 8'h03, 8'h02, 1, 0, '{8'h02, 8'hFF});
    run(8'h11, 8'h03, 8'h07, 1, 0, '{8'h00, 8'h00});
    run(8'h10, 8'h03, 8'h5A, 1, 0, '{8'h00, 8'h00});
    run(8'h03, 8'h03, 8'h00, 0, 1, '{8'h00, 8'h00, 8'h5A, 8'h00,
      8'hFF, 8'h00, 8'h7F, 8'h00});
  endtask
  task automatic sc_offset();
    run(8'h16, 8'h00, 8'hA5, 1, 0, '{8'h00, 8'h00});
    run(8'h02, 8'h00, 8'h00, 0, 0, '{8'h00, 8'h00, 8'hA5, 8'h00});
  endtask
  task automatic sc_mux();
    run(8'h04, 8'h00, 8'h00, 0, 0, '{8'h03, 8'h00});
    run(8'h21, 8'h00, 8'h00, 0, 0, '{8'h00, 8'h00});
    run(8'h04, 8'h00, 8'h00, 0, 0, '{8'h83, 8'h00});
    run(8'h20, 8'h00, 8'h00, 0, 0, '{8'h00, 8'h00});
  endtask
  task automatic sc_ident();
    logic [7:0] e[$];
    logic [127:0] t = "AMP16 Version 10"; // arbitrary default text
    e = '{8'h01, 8'h00, 8'h00, 8'h00};
    for (int k = 0; k < 16; k++) e = {e, t[127 - 8 * k -: 8], 8'h00};
    run(8'h00, 8'h00, 8'h00, 0, 0, e);
  endtask
  // untouched channels keep reset values, bar the common polarity
  task automatic sc_cfg();
    logic [7:0] e[$];
    logic [7:0] g[$];
    logic [7:0] f, p, s;
    e = {};
    for (int c = 0; c < 16; c++) begin
      f = (c == 3) ? 8'h5A : 8'h00;
      p = (c == 3) ? 8'hFF : 8'h00;
      s = (c == 3) ? 8'h7F : 8'h20;
      e = {e, f, 8'h00, p, 8'h00, s, 8'h00};
    end
    g = {8'h00, 8'h00, e};
    run(8'h03, 8'h10, 8'h00, 0, 0, g);
    g = {8'h01, 8'h00, 8'h00, 8'h00, e, 8'hA5, 8'h00};
    run(8'h01, 8'h00, 8'h00, 0, 1, g);
  endtask
  // bad code, busy display, unmapped register
  task automatic sc_err();
    run(8'h05, 8'h00, 8'h00, 0, 0, '{8'h01, 8'hFF});
    axw(8'h00, 32'h00000001);
    axr(8'h00, 32'h00000001, 2'h0);
    run(8'h12, 8'h03, 8'h00, 1, 0, '{8'h00, 8'hFF});
    axw(8'h00, 32'h00000000);
    run(8'h03, 8'h03, 8'h00, 0, 0, '{8'h00, 8'h00, 8'h5A, 8'h00,
      8'hFF, 8'h00, 8'h7F, 8'h00});
    axr(8'h04, 32'h00300000, 2'h0);
    axr(8'h10, 32'h00000000, 2'h2);
  endtask
  initial begin
    aresetn = 1'b0;
    {awa, ara, wd, awv, wv, bq, arv, rq} = '0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    sc_sets();
    sc_offset();
    sc_mux();
    sc_ident();
    sc_cfg();
    sc_err();
    report_and_stop();
  end
endmodule
